/* File: rtl/smdc_defs.svh */
// Constants and rule summary for the drive control port block
// Behaviour
// - Standard: cylinder on bus 0-9, TAG1 seeks
// - Standard: one status byte, no selection
// - Extended: two cylinder halves, TAG4 then TAG1
// - Extended: head address on bus 0-9
// - Extended: status byte code on unit selects, TAG4
// - Modified: cylinder bits 10-11 on selects 0-1
// - Modified: status byte chosen by TAG4/TAG5
// - Modified: select0 is bus bit10, select3 TAG5
// - Enhanced: eleventh bus bit on spare line
// - SMD-E: upper cylinder bits on bus 7-8
// - SMD-E: seven status bytes via bus 0-1
// - Per-drive variant, mixed drives supported
// - Select one drive before issuing tags
// - Read/write cable same for all variants
`ifndef SMDC_DEFS_SVH
`define SMDC_DEFS_SVH
// ==========================================
// Register offsets (byte addresses)
`define SMDC_REG_CTRL 8'h00
`define SMDC_REG_CMD 8'h04
`define SMDC_REG_ARG 8'h08
`define SMDC_REG_STAT 8'h0c
`define SMDC_REG_IRQ 8'h10
`define SMDC_REG_MASK 8'h14
`define SMDC_REG_VARS 8'h18
`define SMDC_REG_SBYTE 8'h1c
// ==========================================
// Command codes
`define SMDC_CMD_SEEK 3'h1
`define SMDC_CMD_HEAD 3'h2
`define SMDC_CMD_CTL 3'h3
`define SMDC_CMD_STSEL 3'h4
// ==========================================
// Status line bits
`define SMDC_ST_READY 0
`define SMDC_ST_ONCYL 1
`define SMDC_ST_SEEKERR 2
`define SMDC_ST_FAULT 3
// Interrupt bits
`define SMDC_IRQ_DONE 0
`define SMDC_IRQ_SEEKERR 1
`define SMDC_IRQ_FAULT 2
`define SMDC_IRQ_ONCYL 3
// ==========================================
// Timing: setup/hold around each strobe in clk cycles, strobe width
`define SMDC_SETUP_CYC 5'h0a
`define SMDC_STROBE_CYC 5'h14
`define SMDC_HOLD_CYC 5'h0a
`define SMDC_VARS_RST 16'h0000
// Cycles after reset before the synchronised status lines are trusted
`define SMDC_SYNC_FILL 2'h3
`endif

/* File: rtl/smdc_pkg.sv */
// Types for the drive control port block
package smdc_pkg;
  // Interface variant per drive
  typedef enum logic [2:0] {
    SMDC_STD = 3'b000,
    SMDC_EXT = 3'b001,
    SMDC_MOD = 3'b010,
    SMDC_ENH = 3'b011,
    SMDC_SMDE = 3'b100
  } smdc_var_e;
  // Strobe sequencer states
  typedef enum logic [2:0] {
    SMDC_IDLE = 3'b000,
    SMDC_SETUP = 3'b001,
    SMDC_STRB = 3'b010,
    SMDC_HOLD = 3'b011,
    SMDC_NEXT = 3'b100
  } smdc_st_e;
endpackage

/* File: rtl/smdc_sync.sv */
// Two-flop synchroniser for a group of drive inputs
`timescale 1ns/1ps
module smdc_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  // First flop only feeds the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule

/* File: rtl/smdc_port.sv */
// Drive control cable port with Wishbone register file
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "smdc_defs.svh"
module smdc_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Control cable outputs
  output logic sel_en_o,
  output logic [3:0] unit_sel_o,
  output logic [10:0] tag_bus_o,
  output logic tag1_o,
  output logic tag2_o,
  output logic tag3_o,
  output logic tag4_o,
  output logic if_en_o,
  // Control cable inputs
  input wire logic [7:0] drv_status_i,
  // Read/write cable
  input wire logic rw_selected_i,
  input wire logic rw_seek_end_i,
  input wire logic rw_read_clk_i,
  input wire logic rw_read_data_i,
  output logic xfer_ready_o
);
  // ==========================================
  // Input synchronisers
  logic [7:0] st_s;
  logic [3:0] rw_s;
  smdc_sync #(.W(8)) u_st (.clk_i(clk_i), .rst_i(rst_i), .d_i(drv_status_i), .q_o(st_s));
  smdc_sync #(.W(4)) u_rw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    // Read data takes the same two flops as its clock, so both stay aligned
    .d_i({rw_read_data_i, rw_selected_i, rw_seek_end_i, rw_read_clk_i}),
    .q_o(rw_s)
  );
  logic rclk_d_ff;
  logic [7:0] rd_sh_ff;
  // ==========================================
  // Registers
  logic [3:0] unit_ff; // Selected drive
  logic if_en_ff; // Interface enable
  logic [15:0] vars_ff; // 4 drives x 4 bits variant code
  logic [19:0] arg_ff; // Command argument
  logic [2:0] cmd_ff; // Command latched
  logic [3:0] irq_ff; // Sticky events
  logic [3:0] mask_ff; // Interrupt mask
  logic [7:0] sbyte_ff; // Status lines at the last sequence end
  smdc_pkg::smdc_st_e st_ff;
  logic [4:0] cnt_ff;
  logic phase_ff; // Second strobe pending
  logic go_p; // Command write pulse
  logic done_p; // Sequence end pulse
  logic wr_req;
  smdc_pkg::smdc_var_e var_sel;
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign go_p = wr_req & (wb_adr_i == `SMDC_REG_CMD) & (st_ff == smdc_pkg::SMDC_IDLE);
  // Variant of the addressed drive, four bits per unit
  always_comb
  begin
    var_sel = smdc_pkg::smdc_var_e'(vars_ff[{unit_ff[1:0], 2'b00} +: 3]);
  end
  // ==========================================
  // Bus: ack one cycle after request, dropped the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end
  // Read mux, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
    begin
      unique case (wb_adr_i)
        `SMDC_REG_CTRL: wb_dat_o <= {27'h0, if_en_ff, unit_ff};
        `SMDC_REG_ARG: wb_dat_o <= {12'h0, arg_ff};
        `SMDC_REG_STAT: wb_dat_o <= {22'h0, rd_sh_ff, st_ff != smdc_pkg::SMDC_IDLE, st_s[1]};
        `SMDC_REG_IRQ: wb_dat_o <= {28'h0, irq_ff};
        `SMDC_REG_MASK: wb_dat_o <= {28'h0, mask_ff};
        `SMDC_REG_VARS: wb_dat_o <= {16'h0, vars_ff};
        `SMDC_REG_SBYTE: wb_dat_o <= {24'h0, sbyte_ff};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end
  // Control writes; unit cannot change mid-sequence
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unit_ff <= 4'h0;
      if_en_ff <= 1'b0;
      vars_ff <= `SMDC_VARS_RST;
      arg_ff <= 20'h0;
      mask_ff <= 4'h0;
      cmd_ff <= 3'h0;
    end
    else if (wr_req)
    begin
      if (wb_adr_i == `SMDC_REG_CTRL && st_ff == smdc_pkg::SMDC_IDLE)
      begin
        unit_ff <= wb_dat_i[3:0];
        if_en_ff <= wb_dat_i[4];
      end
      if (wb_adr_i == `SMDC_REG_ARG && st_ff == smdc_pkg::SMDC_IDLE)
        arg_ff <= wb_dat_i[19:0];
      if (wb_adr_i == `SMDC_REG_MASK)
        mask_ff <= wb_dat_i[3:0];
      if (wb_adr_i == `SMDC_REG_VARS)
        vars_ff <= wb_dat_i[15:0];
      if (go_p)
        cmd_ff <= wb_dat_i[2:0];
    end
  end
  // ==========================================
  // Strobe sequencer: setup, strobe, hold, optional second strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= smdc_pkg::SMDC_IDLE;
      cnt_ff <= 5'h0;
      phase_ff <= 1'b0;
    end
    else
    begin
      unique case (st_ff)
        smdc_pkg::SMDC_IDLE:
        begin
          if (go_p)
          begin
            st_ff <= smdc_pkg::SMDC_SETUP;
            cnt_ff <= `SMDC_SETUP_CYC;
            // Extended seek uses two halves
            phase_ff <= (wb_dat_i[2:0] == `SMDC_CMD_SEEK) && (var_sel == smdc_pkg::SMDC_EXT);
          end
        end
        smdc_pkg::SMDC_SETUP:
        begin
          cnt_ff <= cnt_ff - 5'h1;
          if (cnt_ff == 5'h1)
          begin
            st_ff <= smdc_pkg::SMDC_STRB;
            cnt_ff <= `SMDC_STROBE_CYC;
          end
        end
        smdc_pkg::SMDC_STRB:
        begin
          cnt_ff <= cnt_ff - 5'h1;
          if (cnt_ff == 5'h1)
          begin
            st_ff <= smdc_pkg::SMDC_HOLD;
            cnt_ff <= `SMDC_HOLD_CYC;
          end
        end
        smdc_pkg::SMDC_HOLD:
        begin
          cnt_ff <= cnt_ff - 5'h1;
          if (cnt_ff == 5'h1)
            st_ff <= phase_ff ? smdc_pkg::SMDC_NEXT : smdc_pkg::SMDC_IDLE;
        end
        smdc_pkg::SMDC_NEXT:
        begin
          phase_ff <= 1'b0;
          st_ff <= smdc_pkg::SMDC_SETUP;
          cnt_ff <= `SMDC_SETUP_CYC;
        end
        default: st_ff <= smdc_pkg::SMDC_IDLE;
      endcase
    end
  end
  assign done_p = (st_ff == smdc_pkg::SMDC_HOLD) && (cnt_ff == 5'h1) && !phase_ff;
  // ==========================================
  // Cable drive: bus and selects held from setup through hold
  logic strobe;
  assign strobe = (st_ff == smdc_pkg::SMDC_STRB);
  always_comb
  begin
    tag_bus_o = 11'h0;
    unit_sel_o = unit_ff;
    tag1_o = 1'b0;
    tag2_o = 1'b0;
    tag3_o = 1'b0;
    tag4_o = 1'b0;
    if (st_ff != smdc_pkg::SMDC_IDLE)
    begin
      unique case (cmd_ff)
        `SMDC_CMD_SEEK:
        begin
          unique case (var_sel)
            smdc_pkg::SMDC_EXT:
            begin
              // Upper half with TAG4 first, lower half with TAG1
              tag_bus_o = phase_ff ? {1'b0, arg_ff[19:10]} : {1'b0, arg_ff[9:0]};
              tag4_o = strobe & phase_ff;
              tag1_o = strobe & ~phase_ff;
            end
            smdc_pkg::SMDC_MOD:
            begin
              tag_bus_o = {1'b0, arg_ff[9:0]};
              unit_sel_o = {unit_ff[3:2], arg_ff[11:10]};
              tag1_o = strobe;
            end
            smdc_pkg::SMDC_ENH:
            begin
              tag_bus_o = arg_ff[10:0];
              tag1_o = strobe;
            end
            smdc_pkg::SMDC_SMDE:
            begin
              tag_bus_o = {2'b0, arg_ff[11:10], arg_ff[6:0]};
              tag1_o = strobe;
            end
            default:
            begin
              tag_bus_o = {1'b0, arg_ff[9:0]};
              tag1_o = strobe;
            end
          endcase
        end
        `SMDC_CMD_HEAD:
        begin
          tag_bus_o = {1'b0, arg_ff[9:0]};
          tag2_o = strobe;
        end
        `SMDC_CMD_CTL:
        begin
          tag_bus_o = {1'b0, arg_ff[9:0]};
          tag3_o = strobe;
        end
        `SMDC_CMD_STSEL:
        begin
          unique case (var_sel)
            smdc_pkg::SMDC_EXT:
            begin
              unit_sel_o = arg_ff[3:0];
              tag4_o = strobe;
            end
            smdc_pkg::SMDC_MOD:
            begin
              // Select0 carries bus bit10, select3 is TAG5
              tag_bus_o = {arg_ff[1], 10'h0};
              unit_sel_o = {strobe, unit_ff[2:1], arg_ff[1]};
              tag4_o = strobe & arg_ff[0];
            end
            smdc_pkg::SMDC_SMDE:
            begin
              tag_bus_o = {9'h0, arg_ff[1:0]};
              unit_sel_o = {strobe, unit_ff[2:0]};
              tag4_o = strobe & arg_ff[2];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end
  assign sel_en_o = 1'b1;
  assign if_en_o = if_en_ff;
  // ==========================================
  // Status byte capture at end of every command sequence, whatever the command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sbyte_ff <= 8'h0;
    else if (done_p)
      sbyte_ff <= st_s;
  end
  // Read data shifted on read clock rising edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rclk_d_ff <= 1'b0;
      rd_sh_ff <= 8'h0;
    end
    else
    begin
      rclk_d_ff <= rw_s[0];
      if (rw_s[0] & ~rclk_d_ff)
        rd_sh_ff <= {rd_sh_ff[6:0], rw_s[3]};
    end
  end
  // ==========================================
  // Events: set wins over write-one-to-clear
  logic [3:0] ev;
  logic oncyl_d_ff;
  logic [1:0] fill_ff; // Cycles since reset, saturating
  // The synchroniser restarts at zero, so an idle on-cylinder line would look
  // like a fresh rise; the edge is ignored until the flops hold the pin value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oncyl_d_ff <= 1'b0;
      fill_ff <= 2'h0;
    end
    else
    begin
      oncyl_d_ff <= st_s[`SMDC_ST_ONCYL];
      if (fill_ff != `SMDC_SYNC_FILL)
        fill_ff <= fill_ff + 2'h1;
    end
  end
  assign ev = {st_s[`SMDC_ST_ONCYL] & ~oncyl_d_ff & (fill_ff == `SMDC_SYNC_FILL),
               st_s[`SMDC_ST_FAULT],
               st_s[`SMDC_ST_SEEKERR], done_p};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_ff <= 4'h0;
    else if (wr_req && wb_adr_i == `SMDC_REG_IRQ)
      irq_ff <= (irq_ff & ~wb_dat_i[3:0]) | ev;
    else
      irq_ff <= irq_ff | ev;
  end
  assign irq_o = |(irq_ff & mask_ff);
  // Transfer may start only when ready, on cylinder and free of errors
  assign xfer_ready_o = st_s[`SMDC_ST_READY] & st_s[`SMDC_ST_ONCYL] & ~st_s[`SMDC_ST_FAULT]
                        & ~st_s[`SMDC_ST_SEEKERR] & rw_s[2];
endmodule

/* File: sim/smdc_drive_model.sv */
// Behavioural drive at the far end of both cables
`timescale 1ns/1ps
module smdc_drive_model #(
  parameter int SEEK_CYC = 30
) (
  // Clock and seek strobe
  input wire logic clk_i,
  input wire logic tag1_i,
  // Faults and frames ordered by the bench
  input wire logic err_i,
  input wire logic fault_i,
  input wire logic frame_i,
  // Drive answers
  output logic [7:0] status_o,
  output logic selected_o,
  output logic seek_end_o,
  output logic read_clk_o,
  output logic read_data_o
);
  // ==========================================
  // Seek timing: on-cylinder drops for a fixed span
  int busy_cnt = 0;
  logic t1_ff = 1'b0;
  logic [7:0] pat = 8'h5a;
  // A rising seek strobe restarts the arm travel
  always_ff @(posedge clk_i)
  begin
    t1_ff <= tag1_i;
    if (tag1_i && !t1_ff) busy_cnt <= SEEK_CYC;
    else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
  end
  // Eight status lines, upper four idle
  assign status_o = {4'h0, fault_i, err_i, busy_cnt == 0, 1'b1};
  assign selected_o = 1'b1;
  assign seek_end_o = (busy_cnt == 0) | err_i;
  // ==========================================
  // Read clock runs only within frames and carries one byte, first bit the MSB;
  // data changes on the falling clock, between frames the clock stands low
  logic pend = 1'b0;
  int nbit = 0;
  initial
  begin
    read_clk_o = 1'b0;
    read_data_o = 1'b0;
    forever
    begin
      #62.5;
      if (!frame_i)
      begin
        read_clk_o = 1'b0;
        read_data_o = ~read_data_o;
        nbit = 0;
        pend = 1'b0;
      end
      else if (pend)
      begin
        read_clk_o = 1'b1;
        pend = 1'b0;
      end
      else
      begin
        read_clk_o = 1'b0;
        if (nbit < 8)
        begin
          read_data_o = pat[7 - nbit];
          nbit++;
          pend = 1'b1;
        end
      end
    end
  end
endmodule

/* File: sim/smdc_port_sva.sv */
// Pin checks for the drive control port
`timescale 1ns/1ps
module smdc_port_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Cable pins
  input wire logic irq_o,
  input wire logic sel_en_o,
  input wire logic [3:0] unit_sel_o,
  input wire logic [10:0] tag_bus_o,
  input wire logic tag1_o,
  input wire logic tag2_o,
  input wire logic tag3_o,
  input wire logic tag4_o,
  input wire logic [7:0] drv_status_i,
  input wire logic xfer_ready_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Any strobe on the cable
  logic any_t;
  assign any_t = tag1_o | tag2_o | tag3_o | tag4_o;
  // ==========================================
  // Bus answer
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ackp;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackp: assert property (p_ackp) else $error("ack too long");
  // ==========================================
  // Cable strobes
  property p_selen;
    sel_en_o;
  endproperty
  a_selen: assert property (p_selen) else $error("select off");
  property p_width;
    $rose(any_t) |-> ##19 any_t ##1 !any_t;
  endproperty
  a_width: assert property (p_width) else $error("strobe width");
  property p_stab;
    any_t && $past(any_t) |-> $stable(tag_bus_o) && $stable(unit_sel_o);
  endproperty
  a_stab: assert property (p_stab) else $error("bus moved");
  property p_setup;
    $rose(any_t) |-> $stable(tag_bus_o) && $stable(unit_sel_o[2:0]);
  endproperty
  a_setup: assert property (p_setup) else $error("no setup");
  property p_hold;
    $fell(any_t) |-> $stable(tag_bus_o)[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_one;
    $onehot0({tag1_o, tag2_o, tag3_o, tag4_o});
  endproperty
  a_one: assert property (p_one) else $error("two strobes");
  property p_xfer;
    $past(drv_status_i[3], 2) && $past(drv_status_i[3], 3) |-> !xfer_ready_o;
  endproperty
  a_xfer: assert property (p_xfer) else $error("ready on fault");
  c_seek: cover property ($rose(tag1_o));
  c_stsel: cover property ($rose(tag4_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind smdc_port smdc_port_sva i_smdc_port_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .sel_en_o(sel_en_o), .unit_sel_o(unit_sel_o), .tag_bus_o(tag_bus_o),
  .tag1_o(tag1_o), .tag2_o(tag2_o), .tag3_o(tag3_o), .tag4_o(tag4_o),
  .drv_status_i(drv_status_i), .xfer_ready_o(xfer_ready_o));

/* File: sim/smdc_port_test.sv */
// Self-checking bench for the drive control port
`timescale 1ns/1ps
`include "smdc_defs.svh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module smdc_port_test;
  // ==========================================
  // Bench signals
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic err = 1'b0, flt = 1'b0, frame = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, irq, selen, t1, t2, t3, t4, ifen, xfer, sel, send, rclk, rdat1;
  logic [3:0] usel;
  logic [10:0] bus;
  logic [7:0] st;
  int bad_count = 0, n_checks = 0;
  // One row: variant map, unit, command, argument and expected pins
  typedef struct packed {
    logic [15:0] vars;
    logic [3:0] unit;
    logic [2:0] cmd;
    logic [19:0] arg;
    logic [10:0] bus;
    logic [10:0] bm;
    logic [3:0] us;
    logic [3:0] um;
    logic [3:0] tg;
  } smdc_row_s;
  smdc_row_s rows [11] = '{
    '{16'h0, 4'h1, 3'h1, 20'h003ff, 11'h3ff, 11'h3ff, 4'h1, 4'hf, 4'h1},
    '{16'h2143, 4'h2, 3'h1, 20'habcde, 11'h2af, 11'h3ff, 4'h2, 4'hf, 4'h8},
    '{16'h2143, 4'h3, 3'h1, 20'h00fff, 11'h3ff, 11'h3ff, 4'h3, 4'h3, 4'h1},
    '{16'h2143, 4'h0, 3'h1, 20'h007ff, 11'h7ff, 11'h7ff, 4'h0, 4'hf, 4'h1},
    '{16'h2143, 4'h1, 3'h1, 20'h00c05, 11'h185, 11'h3ff, 4'h1, 4'hf, 4'h1},
    '{16'h2143, 4'h2, 3'h2, 20'h00155, 11'h155, 11'h3ff, 4'h2, 4'hf, 4'h2},
    '{16'h2143, 4'h2, 3'h4, 20'h00009, 11'h0, 11'h0, 4'h9, 4'hf, 4'h8},
    '{16'h2143, 4'h3, 3'h4, 20'h00003, 11'h0, 11'h0, 4'h9, 4'h9, 4'h8},
    '{16'h2143, 4'h1, 3'h4, 20'h00006, 11'h2, 11'h3, 4'h8, 4'h8, 4'h8},
    '{16'h0, 4'h0, 3'h3, 20'h0002a, 11'h2a, 11'h3ff, 4'h0, 4'hf, 4'h4},
    '{16'h0, 4'h0, 3'h4, 20'h0000f, 11'h0, 11'h0, 4'h0, 4'h0, 4'h0}};
  smdc_port i_smdc_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .sel_en_o(selen), .unit_sel_o(usel), .tag_bus_o(bus),
    .tag1_o(t1), .tag2_o(t2), .tag3_o(t3), .tag4_o(t4), .if_en_o(ifen),
    .drv_status_i(st), .rw_selected_i(sel), .rw_seek_end_i(send), .rw_read_clk_i(rclk),
    .rw_read_data_i(rdat1), .xfer_ready_o(xfer));
  smdc_drive_model i_smdc_drive_model (.clk_i(clk_i), .tag1_i(t1), .err_i(err),
    .fault_i(flt), .frame_i(frame), .status_o(st), .selected_o(sel), .seek_end_o(send),
    .read_clk_o(rclk), .read_data_o(rdat1));
  initial forever #2.5 clk_i = ~clk_i;
  // ==========================================
  // One classic bus cycle; the request holds until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 20) bad_count++;
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  // Wait for a strobe, bounded so a silent command is seen too
  task automatic strb;
    int n;
    n = 0;
    while ({t4, t3, t2, t1} === 4'h0 && n < 60)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // Poll busy off, then clear every event
  task automatic idle;
    int n;
    n = 0;
    q = 32'h2;
    while (q[1] !== 1'b0 && n < 100)
    begin
      wb(1'b0, `SMDC_REG_STAT, 32'h0);
      n++;
    end
    if (q[1] !== 1'b0) bad_count++;
    wb(1'b1, `SMDC_REG_IRQ, 32'hf);
  endtask
  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("selen", 1'b1, selen)
    `CHK("irq", 1'b0, irq)
    wb(1'b0, `SMDC_REG_VARS, 32'h0);
    `CHK("vars", `SMDC_VARS_RST, q[15:0])
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, q)
    foreach (rows[i])
    begin
      wb(1'b1, `SMDC_REG_VARS, {16'h0, rows[i].vars});
      wb(1'b1, `SMDC_REG_CTRL, {27'h0, 1'b1, rows[i].unit});
      wb(1'b1, `SMDC_REG_ARG, {12'h0, rows[i].arg});
      wb(1'b1, `SMDC_REG_CMD, {29'h0, rows[i].cmd});
      strb;
      `CHK("tags", rows[i].tg, {t4, t3, t2, t1})
      `CHK("bus", rows[i].bus, bus & rows[i].bm)
      `CHK("usel", rows[i].us, usel & rows[i].um)
      idle;
    end
    `CHK("ifen", 1'b1, ifen)
    // Status byte taken at the end of the last sequence: ready and on cylinder
    wb(1'b0, `SMDC_REG_SBYTE, 32'h0);
    `CHK("sbyte", 8'h03, q[7:0])
    // Argument rewritten while busy must not reach the cable
    wb(1'b1, `SMDC_REG_ARG, 32'h155);
    wb(1'b1, `SMDC_REG_CMD, 32'h1);
    wb(1'b1, `SMDC_REG_ARG, 32'h0aa);
    strb;
    `CHK("busy arg", 11'h155, bus)
    idle;
    // Extended seek: the lower half follows with the seek strobe
    wb(1'b1, `SMDC_REG_VARS, 32'h1);
    wb(1'b1, `SMDC_REG_ARG, 32'habcde);
    wb(1'b1, `SMDC_REG_CMD, 32'h1);
    strb;
    repeat (25) @(posedge clk_i);
    strb;
    `CHK("lo tag", 4'h1, {t4, t3, t2, t1})
    `CHK("lo half", 11'h0de, bus)
    idle;
    repeat (40) @(posedge clk_i);
    `CHK("xfer", 1'b1, xfer)
    // Seek error and fault raise events, only the fault unmasked
    wb(1'b1, `SMDC_REG_MASK, 32'h4);
    {err, flt} <= 2'b11;
    repeat (6) @(posedge clk_i);
    `CHK("xfer off", 1'b0, xfer)
    `CHK("irq on", 1'b1, irq)
    wb(1'b0, `SMDC_REG_IRQ, 32'h0);
    `CHK("events", 2'b11, q[2:1])
    {err, flt} <= 2'b00;
    wb(1'b1, `SMDC_REG_MASK, 32'h0);
    `CHK("masked", 1'b0, irq)
    wb(1'b1, `SMDC_REG_IRQ, 32'h6);
    wb(1'b0, `SMDC_REG_IRQ, 32'h0);
    `CHK("cleared", 2'b00, q[2:1])
    // Reset in mid-sequence drops the strobe and the busy flag
    wb(1'b1, `SMDC_REG_CMD, 32'h1);
    strb;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("rst tags", 4'h0, {t4, t3, t2, t1})
    wb(1'b0, `SMDC_REG_STAT, 32'h0);
    `CHK("rst busy", 1'b0, q[1])
    // Read link traffic: the drive sends one byte per frame
    frame <= 1'b1;
    repeat (400) @(posedge clk_i);
    frame <= 1'b0;
    wb(1'b0, `SMDC_REG_STAT, 32'h0);
    `CHK("rd byte", 8'h5a, q[9:2])
    summarize;
  end
  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    #100us;
    bad_count++;
    summarize;
  end
endmodule
